// [logic/sarsq_top.sv]
// Sequencer control for a twelve-bit successive-approximation converter
`timescale 1ns/1ps
module sarsq_top
   import sarsq_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic [11:0] i_paddr,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_lowpower,
   input wire logic i_cmp,
   output logic o_conv_clk_en,
   output logic [CH_W-1:0] o_mux_sel,
   output logic o_temp_sel,
   output logic [1:0] o_ref_sel,
   output logic o_sample,
   output logic [RES_BITS-1:0] o_dac,
   output logic o_res_valid,
   input wire logic i_res_ready,
   output logic [RES_BITS-1:0] o_res_data,
   output logic [CH_W-1:0] o_res_ch,
   output logic o_range_irq
);
   // ----------------------------------------
   // Register file
   // ----------------------------------------
   logic [31:0] ctrl_q;
   logic [NUM_CH-1:0] chen_q;
   logic [RES_BITS-1:0] lim_lo_q, lim_hi_q;
   logic [NUM_CH-1:0] range_q;
   logic [SMP_W-1:0] smp_q [NUM_CH];
   logic [RES_BITS-1:0] res_q [NUM_CH];
   logic [NUM_CH-1:0] done_q;
   logic step_req_q;
   wire wr = i_psel && i_penable && i_pwrite;
   wire rd_acc = i_psel && i_penable;
   wire [2:0] idx = i_paddr[4:2];
   wire in_smp = i_paddr[11:5] == ADDR_SMP0[11:5];
   wire in_res = i_paddr[11:5] == ADDR_RES0[11:5];
   wire mapped = in_smp || in_res || i_paddr == ADDR_CTRL || i_paddr == ADDR_CHEN
      || i_paddr == ADDR_LIMIT || i_paddr == ADDR_STATUS || i_paddr == ADDR_RANGE
      || i_paddr == ADDR_STEP || i_paddr == ADDR_ID;
   wire aligned = i_paddr[1:0] == 2'b00;
   wire bad = !mapped || !aligned || (in_res && i_pwrite);
   wire en = ctrl_q[CTRL_EN_B] && !i_lowpower;
   wire fw_step = ctrl_q[CTRL_FWSTEP_B];
   wire [3:0] aperture = ctrl_q[CTRL_AP_LSB +: 4];
   assign o_pready = 1'b1;
   assign o_pslverr = rd_acc && bad;
   assign o_temp_sel = ctrl_q[CTRL_TEMP_B];
   assign o_ref_sel = ctrl_q[CTRL_REF_LSB +: 2];
   always_comb begin
      o_prdata = 32'h0000_0000;
      if (rd_acc && !i_pwrite && !bad) begin
         if (in_smp) o_prdata = {24'h000000, smp_q[idx]};
         else if (in_res) o_prdata = {20'h00000, res_q[idx]};
         else if (i_paddr == ADDR_CTRL) o_prdata = ctrl_q;
         else if (i_paddr == ADDR_CHEN) o_prdata = {24'h000000, chen_q};
         else if (i_paddr == ADDR_LIMIT) o_prdata = {4'h0, lim_hi_q, 4'h0, lim_lo_q};
         else if (i_paddr == ADDR_STATUS) o_prdata = {16'h0000, done_q, 7'h00, en};
         else if (i_paddr == ADDR_RANGE) o_prdata = {24'h000000, range_q};
         else if (i_paddr == ADDR_ID) o_prdata = ID_VALUE;
      end
   end
   // ----------------------------------------
   // Converter clock enable
   // ----------------------------------------
   logic [7:0] div_q;
   wire tick = div_q == 8'(CONV_DIV - 1);
   always_ff @(posedge i_clk) begin
      if (i_srst || tick) div_q <= 8'h00;
      else div_q <= div_q + 8'h01;
   end
   assign o_conv_clk_en = tick && en;
   // ----------------------------------------
   // Scan machine
   // ----------------------------------------
   sarsq_state_t st_q;
   logic [CH_W-1:0] ch_q;
   logic [8:0] cnt_q;
   logic [RES_BITS-1:0] sar_q;
   logic [3:0] bit_q;
   // Next enabled channel after the current one
   logic [CH_W-1:0] nxt_ch;
   always_comb begin
      nxt_ch = ch_q;
      for (int k = NUM_CH; k >= 1; k--) begin
         if (chen_q[CH_W'(32'(ch_q) + k)]) nxt_ch = CH_W'(32'(ch_q) + k);
      end
   end
   wire [8:0] smp_len = 9'(smp_q[ch_q]) + 9'(aperture);
   // Sample phase padded so sample plus conversion is never under the minimum
   wire [8:0] conv_pad = 9'(CONV_CLOCKS - RES_BITS);
   wire buf_ready;
   wire go_next = !fw_step || step_req_q;
   assign o_mux_sel = ch_q;
   assign o_sample = st_q == ST_SAMPLE;
   assign o_dac = sar_q;
   always_ff @(posedge i_clk) begin
      if (i_srst || !en) begin
         st_q <= ST_IDLE;
         ch_q <= '0;
         cnt_q <= '0;
         sar_q <= '0;
         bit_q <= 4'(RES_BITS - 1);
      end else if (tick) begin
         case (st_q)
            ST_IDLE: begin
               if (go_next && chen_q != '0) begin
                  st_q <= ST_SAMPLE;
                  cnt_q <= '0;
                  if (!chen_q[ch_q]) ch_q <= nxt_ch;
               end
            end
            ST_SAMPLE: begin
               cnt_q <= cnt_q + 9'h001;
               if (cnt_q + 9'h001 >= smp_len + conv_pad) begin
                  st_q <= ST_CONV;
                  sar_q <= RES_BITS'(1) << (RES_BITS - 1);
                  bit_q <= 4'(RES_BITS - 1);
               end
            end
            ST_CONV: begin
               // One result bit per converter clock
               if (!i_cmp) sar_q[bit_q] <= 1'b0;
               if (bit_q == 4'h0) st_q <= ST_DONE;
               else begin
                  bit_q <= bit_q - 4'h1;
                  sar_q <= (i_cmp ? sar_q : (sar_q & ~(RES_BITS'(1) << bit_q)))
                     | (RES_BITS'(1) << (bit_q - 4'h1));
               end
            end
            ST_DONE: begin
               if (buf_ready) begin
                  cnt_q <= '0;
                  if (go_next) begin
                     st_q <= ST_SAMPLE;
                     ch_q <= nxt_ch;
                  end else begin
                     // Point at the next channel so the following step converts it
                     st_q <= ST_IDLE;
                     ch_q <= nxt_ch;
                  end
               end
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end
   wire conv_done = tick && st_q == ST_DONE && buf_ready && en;
   wire [RES_BITS-1:0] result = sar_q;
   wire out_of_range = (result < lim_lo_q) || (result > lim_hi_q);
   // ----------------------------------------
   // Two-entry result buffer
   // ----------------------------------------
   logic [RES_BITS+CH_W-1:0] fb_q [2];
   logic [1:0] fcnt_q;
   logic frd_q, fwr_q;
   assign buf_ready = fcnt_q != 2'd2;
   assign o_res_valid = fcnt_q != 2'd0;
   assign {o_res_ch, o_res_data} = fb_q[frd_q];
   wire push = conv_done;
   wire pop = o_res_valid && i_res_ready;
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         fcnt_q <= 2'd0;
         frd_q <= 1'b0;
         fwr_q <= 1'b0;
         fb_q[0] <= '0;
         fb_q[1] <= '0;
      end else begin
         if (push) begin
            fb_q[fwr_q] <= {ch_q, result};
            fwr_q <= !fwr_q;
         end
         if (pop) frd_q <= !frd_q;
         fcnt_q <= fcnt_q + 2'(push) - 2'(pop);
      end
   end
   // ----------------------------------------
   // Register writes and status
   // ----------------------------------------
   wire wok = wr && !bad;
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         ctrl_q <= CTRL_RST;
         chen_q <= CHEN_RST;
         lim_lo_q <= LIM_LO_RST;
         lim_hi_q <= LIM_HI_RST;
         range_q <= '0;
         done_q <= '0;
         step_req_q <= 1'b0;
         for (int k = 0; k < NUM_CH; k++) begin
            smp_q[k] <= SMP_RST;
            res_q[k] <= '0;
         end
      end else begin
         if (wok && i_paddr == ADDR_CTRL) ctrl_q <= i_pwdata;
         if (wok && i_paddr == ADDR_CHEN) chen_q <= i_pwdata[7:0];
         if (wok && i_paddr == ADDR_LIMIT) begin
            lim_lo_q <= i_pwdata[11:0];
            lim_hi_q <= i_pwdata[27:16];
         end
         if (wok && in_smp) smp_q[idx] <= i_pwdata[SMP_W-1:0];
         // Step request held until the next converter tick in ST_IDLE or in ST_DONE with buffer space
         if (wok && i_paddr == ADDR_STEP && i_pwdata[0]) step_req_q <= 1'b1;
         else if (tick && (st_q == ST_IDLE || (st_q == ST_DONE && buf_ready))) step_req_q <= 1'b0;
         // Set beats write-one clear
         range_q <= (range_q & ~((wok && i_paddr == ADDR_RANGE) ? i_pwdata[7:0] : 8'h00))
            | ((conv_done && out_of_range) ? (8'h01 << ch_q) : 8'h00);
         done_q <= (done_q & ~((wok && i_paddr == ADDR_STATUS) ? i_pwdata[15:8] : 8'h00))
            | (conv_done ? (8'h01 << ch_q) : 8'h00);
         if (conv_done) res_q[ch_q] <= result;
      end
   end
   assign o_range_irq = range_q != '0;
   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_range_set;
      @(posedge i_clk) disable iff (i_srst) conv_done && out_of_range |=> range_q[$past(ch_q)] && o_range_irq;
   endproperty
   a_range_set: assert property (p_range_set) else $error("range flag not set");
   property p_range_hold;
      @(posedge i_clk) disable iff (i_srst) o_range_irq && !(wok && i_paddr == ADDR_RANGE) |=> o_range_irq;
   endproperty
   a_range_hold: assert property (p_range_hold) else $error("range flag dropped");
   property p_lowpower;
      @(posedge i_clk) disable iff (i_srst) i_lowpower |-> !o_conv_clk_en ##1 st_q == ST_IDLE;
   endproperty
   a_lowpower: assert property (p_lowpower) else $error("active in low power");
   property p_res_store;
      @(posedge i_clk) disable iff (i_srst) conv_done |=> res_q[$past(ch_q)] == $past(result) && done_q[$past(ch_q)];
   endproperty
   a_res_store: assert property (p_res_store) else $error("result not stored");
   property p_ch_enabled;
      @(posedge i_clk) disable iff (i_srst) st_q == ST_CONV |-> chen_q[ch_q] || $past(chen_q[ch_q]);
   endproperty
   a_ch_enabled: assert property (p_ch_enabled) else $error("disabled channel converted");
   property p_conv_len;
      @(posedge i_clk) disable iff (i_srst) $rose(st_q == ST_CONV) |-> cnt_q >= conv_pad;
   endproperty
   a_conv_len: assert property (p_conv_len) else $error("conversion too short");
   property p_res_hold;
      @(posedge i_clk) disable iff (i_srst)
         o_res_valid && !i_res_ready |=> o_res_valid && $stable(o_res_data) && $stable(o_res_ch);
   endproperty
   a_res_hold: assert property (p_res_hold) else $error("result changed while stalled");
   property p_fw_wait;
      @(posedge i_clk) disable iff (i_srst) st_q == ST_IDLE && fw_step && !step_req_q && en |=> st_q == ST_IDLE;
   endproperty
   a_fw_wait: assert property (p_fw_wait) else $error("advanced without step");
   // ----------------------------------------
   // Timing, stepping and stream checks
   // ----------------------------------------
   property p_tick_gap;
      @(posedge i_clk) disable iff (i_srst) o_conv_clk_en |=> !o_conv_clk_en [*5];
   endproperty
   a_tick_gap: assert property (p_tick_gap) else $error("converter clock too fast");
   property p_no_idle;
      @(posedge i_clk) disable iff (i_srst)
         st_q == ST_DONE && tick && buf_ready && go_next && en |=> st_q == ST_SAMPLE;
   endproperty
   a_no_idle: assert property (p_no_idle) else $error("idle gap between channels");
   property p_step_go;
      @(posedge i_clk) disable iff (i_srst)
         st_q == ST_IDLE && tick && en && fw_step && step_req_q && chen_q != '0
         && !(wok && i_paddr == ADDR_STEP) |=> st_q == ST_SAMPLE && !step_req_q;
   endproperty
   a_step_go: assert property (p_step_go) else $error("step not taken");
   property p_mux_stable;
      @(posedge i_clk) disable iff (i_srst) (st_q == ST_SAMPLE || st_q == ST_CONV) && en |=> $stable(o_mux_sel);
   endproperty
   a_mux_stable: assert property (p_mux_stable) else $error("channel moved mid conversion");
   property p_w1c;
      @(posedge i_clk) disable iff (i_srst)
         wok && i_paddr == ADDR_RANGE && !conv_done |=> (range_q & $past(i_pwdata[7:0])) == '0;
   endproperty
   a_w1c: assert property (p_w1c) else $error("range flag not cleared");
   property p_irq_quiet;
      @(posedge i_clk) disable iff (i_srst) !o_range_irq && !(conv_done && out_of_range) |=> !o_range_irq;
   endproperty
   a_irq_quiet: assert property (p_irq_quiet) else $error("range flag set without cause");
   property p_lp_sample;
      @(posedge i_clk) disable iff (i_srst) i_lowpower |=> !o_sample;
   endproperty
   a_lp_sample: assert property (p_lp_sample) else $error("sampling in low power");
   property p_conv_steps;
      @(posedge i_clk) disable iff (i_srst)
         st_q == ST_CONV && tick && en && bit_q != 4'h0 |=> bit_q == $past(bit_q) - 4'h1;
   endproperty
   a_conv_steps: assert property (p_conv_steps) else $error("bit decision skipped");
   property p_conv_end;
      @(posedge i_clk) disable iff (i_srst) st_q == ST_CONV && tick && en && bit_q == 4'h0 |=> st_q == ST_DONE;
   endproperty
   a_conv_end: assert property (p_conv_end) else $error("conversion did not end");
   property p_stall;
      @(posedge i_clk) disable iff (i_srst) st_q == ST_DONE && !buf_ready && en |=> st_q == ST_DONE;
   endproperty
   a_stall: assert property (p_stall) else $error("result dropped while full");
   property p_push_valid;
      @(posedge i_clk) disable iff (i_srst) push |=> o_res_valid;
   endproperty
   a_push_valid: assert property (p_push_valid) else $error("pushed result not offered");
   c_done: cover property (@(posedge i_clk) conv_done);
   c_range: cover property (@(posedge i_clk) conv_done && out_of_range);
   c_full: cover property (@(posedge i_clk) fcnt_q == 2'd2);
   c_step: cover property (@(posedge i_clk) wok && i_paddr == ADDR_STEP);
   c_lowpower: cover property (@(posedge i_clk) i_lowpower && st_q == ST_IDLE);
endmodule // sarsq_top

// [logic/sarsq_pkg.sv]
// Constants, register map and types for the converter sequencer control
//
// Contract
// - The converter clock is at most 18 MHz and every conversion takes at least 18 of its clocks.
// - Every finished conversion yields a twelve-bit result.
// - Eight selectable inputs are stepped through in turn without software help.
// - Moving between channels adds no idle cycles, so the aggregate rate stays the same.
// - Channels advance either by the internal scan machine or by firmware-issued steps.
// - Each channel keeps its own result buffer readable after a scan.
// - Each channel has its own programmable sample time applied when it is converted.
// - Each result is checked against a low and a high limit and a miss is flagged at once.
// - The reference is selectable among supply, half supply, internal reference or external pin.
// - The sample-and-hold aperture length is set by configuration.
// - The on-chip temperature sensor can be selected as a conversion input.
// - Nothing converts while a deep low-power or hibernate state is signalled.
package sarsq_pkg;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int SYS_CLK_MHZ = 100;
   localparam int CONV_CLK_MAX_MHZ = 18;
   // Least division so that the converter clock enable is at most the limit
   localparam int CONV_DIV = (SYS_CLK_MHZ + CONV_CLK_MAX_MHZ - 1) / CONV_CLK_MAX_MHZ;
   localparam int CONV_CLOCKS = 18;
   localparam int RES_BITS = 12;
   localparam int NUM_CH = 8;
   localparam int CH_W = 3;
   localparam int SMP_W = 8;
   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_CHEN = 12'h004;
   localparam logic [11:0] ADDR_LIMIT = 12'h008;
   localparam logic [11:0] ADDR_STATUS = 12'h00C;
   localparam logic [11:0] ADDR_RANGE = 12'h010;
   localparam logic [11:0] ADDR_STEP = 12'h014;
   localparam logic [11:0] ADDR_SMP0 = 12'h020;
   localparam logic [11:0] ADDR_RES0 = 12'h040;
   localparam logic [11:0] ADDR_ID = 12'h060;
   // Arbitrary identification value
   localparam logic [31:0] ID_VALUE = 32'h0000_5A01;
   // ----------------------------------------
   // Control fields
   // ----------------------------------------
   localparam int CTRL_EN_B = 0;
   localparam int CTRL_FWSTEP_B = 1;
   localparam int CTRL_TEMP_B = 2;
   localparam int CTRL_REF_LSB = 4;
   localparam int CTRL_AP_LSB = 8;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [7:0] CHEN_RST = 8'h01;
   localparam logic [SMP_W-1:0] SMP_RST = 8'h04;
   localparam logic [RES_BITS-1:0] LIM_LO_RST = 12'h000;
   localparam logic [RES_BITS-1:0] LIM_HI_RST = 12'hFFF;
   // Reference choices
   typedef enum logic [1:0] {
      REF_VDD = 2'b00,
      REF_VDD_HALF = 2'b01,
      REF_INT = 2'b10,
      REF_EXT = 2'b11
   } sarsq_ref_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SAMPLE = 2'b01,
      ST_CONV = 2'b10,
      ST_DONE = 2'b11
   } sarsq_state_t;
endpackage

// [dv/sarsq_analog.sv]
// Behavioural analog front end: channel levels and comparator
`timescale 1ns/1ps
module sarsq_analog
   import sarsq_pkg::*;
(
   input wire logic [CH_W-1:0] i_mux_sel,
   input wire logic i_temp_sel,
   input wire logic i_sample,
   input wire logic [RES_BITS-1:0] i_dac,
   input wire logic [NUM_CH*RES_BITS-1:0] i_vin,
   input wire logic [RES_BITS-1:0] i_temp,
   output logic o_cmp
);
   logic [RES_BITS-1:0] level;
   // Selected source, the sensor overrides the pin mux
   assign level = i_temp_sel ? i_temp : i_vin[i_mux_sel*RES_BITS +: RES_BITS];
   // Comparator output is meaningless while tracking, so it follows the inverted DAC LSB
   assign o_cmp = i_sample ? ~i_dac[0] : (i_dac <= level);
endmodule // sarsq_analog

// [dv/sarsq_top_tb_top.sv]
// Self-checking bench for the converter sequencer control
`timescale 1ns/1ps
module sarsq_top_tb_top
   import sarsq_pkg::*;
;
   localparam logic [NUM_CH*RES_BITS-1:0] VIN = {60'h0, 12'hF3C, 12'h7FF, 12'h0A5};
   localparam logic [RES_BITS-1:0] TEMP = 12'h3C3;
   logic i_clk = 1'b0, i_srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, lowpower = 1'b0;
   logic res_ready = 1'b0, pready, pslverr, cmp, clk_en, temp_sel, sample, res_valid, range_irq, last_err;
   logic prev = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic [CH_W-1:0] mux_sel, res_ch, m0, smp_ch;
   logic [1:0] ref_sel;
   logic [RES_BITS-1:0] dac, res_data;
   logic [RES_BITS-1:0] q_d[$];
   logic [CH_W-1:0] q_c[$];
   int err_total = 0, total_checks = 0, cyc = 0, cnt = 0, gap = 0, min_gap = 99, last_rise = 0, base;
   int smp_len[NUM_CH], rise_gap[NUM_CH];

   sarsq_top sarsq_top_i (.i_clk(i_clk), .i_srst(i_srst), .i_paddr(paddr), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_lowpower(lowpower), .i_cmp(cmp), .o_conv_clk_en(clk_en), .o_mux_sel(mux_sel),
      .o_temp_sel(temp_sel), .o_ref_sel(ref_sel), .o_sample(sample), .o_dac(dac), .o_res_valid(res_valid),
      .i_res_ready(res_ready), .o_res_data(res_data), .o_res_ch(res_ch), .o_range_irq(range_irq));
   sarsq_analog sarsq_analog_i (.i_mux_sel(mux_sel), .i_temp_sel(temp_sel), .i_sample(sample),
      .i_dac(dac), .i_vin(VIN), .i_temp(TEMP), .o_cmp(cmp));

   initial begin
      forever #5 i_clk = ~i_clk;
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic final_report();
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // One APB transfer, entered just after a rising edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge i_clk);
      penable <= 1'b1;
      // A hang here ends at the cycle ceiling
      do begin
         @(posedge i_clk);
      end while (pready !== 1'b1);
      q = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge i_clk);
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge i_clk);
   endtask

   task automatic wait_res(input int n);
      while (q_d.size() < n) begin
         @(posedge i_clk);
      end
   endtask

   // ----------------------------------------
   // Stream, tick and timeout monitor
   // ----------------------------------------
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 60000) begin
         err_total++;
         final_report();
      end
      if (res_valid && res_ready) begin
         q_d.push_back(res_data);
         q_c.push_back(res_ch);
      end
      if (clk_en) begin
         if (gap < min_gap) min_gap = gap;
         gap = 1;
      end else gap++;
      if (sample && clk_en) cnt++;
      if (sample && !prev) begin
         rise_gap[mux_sel] = cyc - last_rise;
         last_rise = cyc;
      end
      if (!sample && prev) begin
         smp_len[smp_ch] = cnt;
         cnt = 0;
      end
      if (sample) smp_ch = mux_sel;
      prev = sample;
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      gap = 1000;
      repeat (3) @(posedge i_clk);
      i_srst <= 1'b0;
      apb(0, ADDR_CTRL, 0); chk("ctrl_rst", q, CTRL_RST);
      apb(0, ADDR_CHEN, 0); chk("chen_rst", q, {24'h0, CHEN_RST});
      apb(0, ADDR_LIMIT, 0); chk("limit_rst", q, {4'h0, LIM_HI_RST, 4'h0, LIM_LO_RST});
      apb(0, ADDR_SMP0, 0); chk("smp_rst", q, {24'h0, SMP_RST});
      apb(0, 12'h070, 0); chk("unmapped_err", last_err, 1);
      chk("unmapped_data", q, 0);
      apb(1, ADDR_RES0, 32'h0000_0FFF); chk("res_write_err", last_err, 1);
      for (int r = 0; r < 4; r++) begin
         apb(1, ADDR_CTRL, 32'(r) << CTRL_REF_LSB); chk("ref_sel", ref_sel, r);
      end
      // Three channels, receiver stalled until the buffer backs up
      apb(1, ADDR_CHEN, 32'h07);
      apb(1, ADDR_LIMIT, 32'h0E00_0100);
      apb(1, ADDR_SMP0 + 12'h004, 32'h0A);
      apb(1, ADDR_CTRL, 32'h21);
      tick(1000);
      chk("held_valid", res_valid, 1);
      res_ready <= 1'b1;
      wait_res(6);
      for (int i = 0; i < 6; i++) begin
         chk("res_ch", q_c[i], i % 3);
         chk("res_data", q_d[i], VIN[(i % 3)*RES_BITS +: RES_BITS]);
      end
      chk("smp_delta", smp_len[1] - smp_len[0], 6);
      chk("clk_gap_ok", min_gap >= CONV_DIV, 1);
      base = smp_len[0];
      apb(1, ADDR_CTRL, 0);
      tick(300);
      for (int c = 0; c < 3; c++) begin
         apb(0, ADDR_RES0 + 12'(4*c), 0); chk("res_reg", q, {20'h0, VIN[c*RES_BITS +: RES_BITS]});
      end
      apb(0, ADDR_STATUS, 0); chk("done_flags", q, 32'h0000_0700);
      apb(0, ADDR_RANGE, 0); chk("range", q, 32'h05);
      chk("irq_set", range_irq, 1);
      apb(1, ADDR_RANGE, 32'h01);
      apb(0, ADDR_RANGE, 0); chk("range_w1c", q, 32'h04);
      apb(1, ADDR_RANGE, 32'h04); chk("irq_clr", range_irq, 0);
      // Longer aperture, receiver always ready
      q_d.delete();
      apb(1, ADDR_CTRL, 32'h321);
      wait_res(5);
      chk("aperture", smp_len[0] - base, 3);
      chk("no_idle", rise_gap[1], (SMP_RST + 3 + CONV_CLOCKS + 1) * CONV_DIV);
      // Firmware-driven stepping
      apb(1, ADDR_CTRL, 32'h03);
      tick(300);
      m0 = mux_sel;
      tick(600);
      chk("fw_hold", mux_sel, m0);
      apb(1, ADDR_STEP, 32'h01);
      tick(600);
      chk("fw_step", mux_sel, (m0 == 3'd2) ? 3'd0 : m0 + 3'd1);
      // Temperature sensor input
      apb(1, ADDR_CTRL, 0);
      tick(300);
      apb(1, ADDR_CHEN, 32'h01);
      q_d.delete();
      apb(1, ADDR_CTRL, 32'h05);
      chk("temp_sel", temp_sel, 1);
      wait_res(1);
      chk("temp_res", q_d[0], TEMP);
      // Deep low-power halts scanning
      lowpower <= 1'b1;
      tick(20);
      q_d.delete();
      tick(1000);
      chk("lp_results", q_d.size(), 0);
      chk("lp_sample", sample, 0);
      apb(0, ADDR_STATUS, 0); chk("lp_running", q[0], 0);
      final_report();
   end
endmodule // sarsq_top_tb_top
